// ===== logic/tpdd_top.sv
// Our own choice: register access over APB.
`timescale 1ns/10ps
// What this block does
// - Control bit 7 enables touch interface
// - Read-only bit 5 reports touch detected
// - Bit 4 gates detection onto external line
// - Bits 3..0 close the four drive switches
// - Debounce control bit 7 enables filtering
// - Interval is N times 64 minus 16 clocks
module tpdd_top (
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_TOUCH_RAW,
  output logic             O_TOUCH_INTERFACE_ENABLE,
  output logic             O_PLUS_Y_SWITCH,
  output logic             O_PLUS_X_SWITCH,
  output logic             O_MINUS_Y_SWITCH,
  output logic             O_MINUS_X_SWITCH,
  output logic             O_EXTERNAL_IRQ_LINE_TWO,
  output logic             O_IRQ
);

  localparam int CW = tpdd_pkg::DB_CNT_W;
  localparam int EW = tpdd_pkg::EVT_W;

  logic [7:0]    panel_ctrl;
  logic [7:0]    debounce_ctrl;
  logic [EW-1:0] irq_status;
  logic [EW-1:0] irq_mask;
  logic [EW-1:0] read_snap;
  logic [EW-1:0] events;
  logic          touch_detected_flag;
  logic          touch_filtered;
  logic          touch_gated;
  logic [10:0]   weight_sum;
  logic [CW-1:0] scaled;
  logic [CW-1:0] interval;

  logic [9:0]    idx;
  logic          aligned;
  logic          hit_panel;
  logic          hit_debounce;
  logic          hit_status;
  logic          hit_mask;
  logic          mapped;
  logic          setup_ph;
  logic          access_done;
  logic          wr_done;
  logic          rd_done;
  logic [31:0]   next_rdata;

  // Address decode
  assign idx          = I_PADDR[11:2];
  assign aligned      = (I_PADDR[1:0] == 2'h0);
  assign hit_panel    = aligned && (idx == tpdd_pkg::IDX_PANEL_CTRL);
  assign hit_debounce = aligned && (idx == tpdd_pkg::IDX_DEBOUNCE_CTRL);
  assign hit_status   = aligned && (idx == tpdd_pkg::IDX_IRQ_STATUS);
  assign hit_mask     = aligned && (idx == tpdd_pkg::IDX_IRQ_MASK);
  assign mapped = hit_panel || hit_debounce || hit_status || hit_mask;

  // Zero wait states: every access phase completes at its first edge
  assign setup_ph    = I_PSEL && !I_PENABLE;
  assign O_PREADY    = 1'b1;
  assign access_done = I_PSEL && I_PENABLE;
  assign O_PSLVERR   = access_done && !mapped;
  assign wr_done     = access_done && I_PWRITE && mapped;
  assign rd_done     = access_done && !I_PWRITE && mapped;

  // touch_panel_control: bit 5 is status and bit 6 reads zero
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      panel_ctrl <= tpdd_pkg::PANEL_CTRL_RESET;
    end else if (wr_done && hit_panel) begin
      panel_ctrl <= I_PWDATA[7:0] & tpdd_pkg::PANEL_CTRL_WMASK;
    end
  end

  // touch_debounce_control
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      debounce_ctrl <= tpdd_pkg::DEBOUNCE_CTRL_RESET;
    end else if (wr_done && hit_debounce) begin
      debounce_ctrl <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_mask <= tpdd_pkg::IRQ_MASK_RESET;
    end else if (wr_done && hit_mask) begin
      irq_mask <= I_PWDATA[EW-1:0];
    end
  end

  // Debounce interval from the weighted bits
  always_comb begin
    weight_sum = 11'h000;
    for (int i = 0; i < 7; i++) begin
      if (debounce_ctrl[i]) begin
        weight_sum = weight_sum + tpdd_pkg::DB_WEIGHT[i];
      end
    end
  end

  assign scaled = CW'({weight_sum, 6'h00});

  // N of zero would go negative; one cycle is the shortest wait
  always_comb begin
    if (scaled > tpdd_pkg::DB_OFFSET) begin
      interval = scaled - tpdd_pkg::DB_OFFSET;
    end else begin
      interval = CW'(1);
    end
  end

  // Disabled interface never reports a touch
  assign touch_gated = I_TOUCH_RAW && panel_ctrl[tpdd_pkg::BIT_IF_ENABLE];

  tpdd_debounce #(
    .CNT_W (CW)
  ) u_debounce (
    .i_clk      (I_CORE_CLK),
    .i_rst_b    (I_RST_B),
    .i_enable   (debounce_ctrl[tpdd_pkg::BIT_DB_ENABLE]),
    .i_interval (interval),
    .i_raw      (touch_gated),
    .o_valid    (touch_filtered)
  );

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      touch_detected_flag <= 1'b0;
    end else begin
      touch_detected_flag <= touch_filtered;
    end
  end

  // Detection edges feed the sticky status
  assign events[tpdd_pkg::EVT_TOUCH] =
    touch_filtered && !touch_detected_flag;
  assign events[tpdd_pkg::EVT_RELEASE] =
    !touch_filtered && touch_detected_flag;

  // Snapshot at setup so an event landing mid-read is kept
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      read_snap <= '0;
    end else if (setup_ph) begin
      read_snap <= irq_status;
    end
  end

  // Set wins over the read clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      irq_status <= tpdd_pkg::IRQ_STATUS_RESET;
    end else if (rd_done && hit_status) begin
      irq_status <= (irq_status & ~read_snap) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(((irq_status | events) & irq_mask));
    end
  end

  // Read data is latched in the setup cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_panel) begin
      next_rdata[7:0] = panel_ctrl;
      next_rdata[tpdd_pkg::BIT_DETECTED] = touch_detected_flag;
    end else if (hit_debounce) begin
      next_rdata[7:0] = debounce_ctrl;
    end else if (hit_status) begin
      next_rdata[EW-1:0] = irq_status;
    end else if (hit_mask) begin
      next_rdata[EW-1:0] = irq_mask;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup_ph && !I_PWRITE) begin
      O_PRDATA <= next_rdata;
    end
  end

  // Panel-side outputs
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_TOUCH_INTERFACE_ENABLE <= 1'b0;
      O_PLUS_Y_SWITCH          <= 1'b0;
      O_PLUS_X_SWITCH          <= 1'b0;
      O_MINUS_Y_SWITCH         <= 1'b0;
      O_MINUS_X_SWITCH         <= 1'b0;
    end else begin
      O_TOUCH_INTERFACE_ENABLE <= panel_ctrl[tpdd_pkg::BIT_IF_ENABLE];
      O_PLUS_Y_SWITCH  <= panel_ctrl[tpdd_pkg::BIT_PLUS_Y];
      O_PLUS_X_SWITCH  <= panel_ctrl[tpdd_pkg::BIT_PLUS_X];
      O_MINUS_Y_SWITCH <= panel_ctrl[tpdd_pkg::BIT_MINUS_Y];
      O_MINUS_X_SWITCH <= panel_ctrl[tpdd_pkg::BIT_MINUS_X];
    end
  end

  // Level follows detection; the external controller does the edge work
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_EXTERNAL_IRQ_LINE_TWO <= 1'b0;
    end else begin
      O_EXTERNAL_IRQ_LINE_TWO <= touch_filtered
        && panel_ctrl[tpdd_pkg::BIT_IRQ_ENABLE];
    end
  end

  if_off_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !panel_ctrl[tpdd_pkg::BIT_IF_ENABLE] [*3] |-> !touch_detected_flag)
    else $error("Touch reported while interface disabled");

  flag_read_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    setup_ph && !I_PWRITE && hit_panel
      |=> O_PRDATA[tpdd_pkg::BIT_DETECTED] == $past(touch_detected_flag))
    else $error("Detection bit read back wrong");

  irq_gate_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !panel_ctrl[tpdd_pkg::BIT_IRQ_ENABLE] |=> !O_EXTERNAL_IRQ_LINE_TWO)
    else $error("External interrupt raised while disabled");

  irq_pass_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    touch_filtered && panel_ctrl[tpdd_pkg::BIT_IRQ_ENABLE]
      |=> O_EXTERNAL_IRQ_LINE_TWO)
    else $error("Enabled touch did not reach external interrupt");

  switch_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    wr_done && hit_panel |=> ##1
      O_PLUS_Y_SWITCH == $past(I_PWDATA[tpdd_pkg::BIT_PLUS_Y], 2)
      && O_MINUS_X_SWITCH == $past(I_PWDATA[tpdd_pkg::BIT_MINUS_X], 2))
    else $error("Drive switch does not follow written bit");

  db_bypass_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    !debounce_ctrl[tpdd_pkg::BIT_DB_ENABLE] && touch_gated
      |=> touch_filtered)
    else $error("Unfiltered touch was delayed");

  db_interval_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    debounce_ctrl == 8'h81 |-> interval == 17'h00030)
    else $error("Debounce interval for N of one is not 48");

  db_hold_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    debounce_ctrl[tpdd_pkg::BIT_DB_ENABLE] && $rose(touch_filtered)
      && interval >= 17'h00002 |-> $past(touch_gated, 2))
    else $error("Filtered touch rose without a held raw touch");

  sticky_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    events[tpdd_pkg::EVT_TOUCH] |=> irq_status[tpdd_pkg::EVT_TOUCH])
    else $error("Touch event lost from status");

  irq_level_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    |(irq_status & irq_mask) |=> O_IRQ)
    else $error("Unmasked status bit did not raise interrupt");

  irq_quiet_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    irq_mask == '0 |=> !O_IRQ)
    else $error("Interrupt raised with every source masked");

  // A read clears only what it returned, so a late event is never lost
  read_clear_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    rd_done && hit_status && read_snap[tpdd_pkg::EVT_TOUCH]
      && !events[tpdd_pkg::EVT_TOUCH]
      |=> !irq_status[tpdd_pkg::EVT_TOUCH])
    else $error("Status read did not clear the touch event");

  db_write_a: assert property (
    @(posedge I_CORE_CLK) disable iff (!I_RST_B)
    wr_done && hit_debounce |=> debounce_ctrl == $past(I_PWDATA[7:0]))
    else $error("Debounce control write did not land");

endmodule

// ===== logic/tpdd_pkg.sv
package tpdd_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_PANEL_CTRL   = 10'h02B;
  localparam logic [9:0] IDX_DEBOUNCE_CTRL = 10'h02C;
  localparam logic [9:0] IDX_IRQ_STATUS   = 10'h02D;
  localparam logic [9:0] IDX_IRQ_MASK     = 10'h02E;

  // touch_panel_control fields
  localparam int BIT_IF_ENABLE   = 7;
  localparam int BIT_DETECTED    = 5;
  localparam int BIT_IRQ_ENABLE  = 4;
  localparam int BIT_PLUS_Y      = 3;
  localparam int BIT_PLUS_X      = 2;
  localparam int BIT_MINUS_Y     = 1;
  localparam int BIT_MINUS_X     = 0;
  localparam logic [7:0] PANEL_CTRL_RESET = 8'h00;
  // Bit 5 is status and bit 6 is unused, so neither takes a write
  localparam logic [7:0] PANEL_CTRL_WMASK = 8'h9F;

  // touch_debounce_control fields
  localparam int BIT_DB_ENABLE = 7;
  localparam logic [7:0] DEBOUNCE_CTRL_RESET = 8'h00;

  // Weights of bits 0 up to 6
  localparam logic [10:0] DB_WEIGHT [7] = '{
    11'h001, 11'h002, 11'h004, 11'h008, 11'h040, 11'h100, 11'h400
  };

  // Interval = N * 64 - 16 system clock periods
  localparam int DB_SCALE_SHIFT = 6;
  localparam logic [16:0] DB_OFFSET = 17'h00010;
  localparam int DB_CNT_W = 17;

  // Interrupt status layout
  localparam int EVT_TOUCH   = 0;
  localparam int EVT_RELEASE = 1;
  localparam int EVT_W       = 2;
  localparam logic [EVT_W-1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [EVT_W-1:0] IRQ_MASK_RESET   = 2'h0;

endpackage

// ===== logic/tpdd_debounce.sv
`timescale 1ns/10ps
module tpdd_debounce #(
  parameter int CNT_W = tpdd_pkg::DB_CNT_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_enable,
  input  wire logic [CNT_W-1:0] i_interval,
  input  wire logic             i_raw,
  output logic                  o_valid
);

  logic [CNT_W-1:0] run_cnt;
  logic [CNT_W-1:0] next_run_cnt;

  // Saturating count of consecutive cycles with raw touch present
  always_comb begin
    if (!i_raw) begin
      next_run_cnt = '0;
    end else if (run_cnt == i_interval) begin
      next_run_cnt = run_cnt;
    end else begin
      next_run_cnt = run_cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= next_run_cnt;
    end
  end

  // Release is not filtered so a lifted stylus is seen at once
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
    end else if (!i_enable) begin
      o_valid <= i_raw;
    end else begin
      o_valid <= i_raw && (next_run_cnt == i_interval);
    end
  end

  db_wait_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_enable && $rose(o_valid) |-> $past(run_cnt) + 1'b1 >= i_interval)
    else $error("Debounced touch accepted before interval elapsed");

  db_pass_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    !i_enable |=> o_valid == $past(i_raw))
    else $error("Bypass path did not follow raw touch");

endmodule

// ===== bench/tpdd_panel.sv
`timescale 1ns/10ps
module tpdd_panel (
  input  wire logic i_clk,
  input  wire logic i_press,
  output logic      o_raw
);
  // Contact is sensed on the clock, so the raw level is already synchronous
  initial o_raw = 1'b0;
  always @(posedge i_clk) begin
    o_raw <= i_press;
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  typedef struct {
    logic [11:0] a;
    logic [7:0]  w;
    logic [7:0]  r;
    logic [4:0]  o;
  } tpdd_row_s;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        press = 1'b0;
  logic        raw;
  wire  [4:0]  outs;
  logic        ext;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          iv;
  // Register ordinary cases: write, read back, and switch outputs
  tpdd_row_s rows [4] = '{
    '{12'h0AC, 8'hFF, 8'h9F, 5'h1F}, '{12'h0AC, 8'h0A, 8'h0A, 5'h0A},
    '{12'h0B0, 8'h81, 8'h81, 5'h0A}, '{12'h0B8, 8'h03, 8'h03, 5'h0A}
  };
  always #5 clk = ~clk;
  tpdd_panel i_panel (.i_clk(clk), .i_press(press), .o_raw(raw));
  tpdd_top i_dut (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_TOUCH_RAW(raw), .O_TOUCH_INTERFACE_ENABLE(outs[4]),
    .O_PLUS_Y_SWITCH(outs[3]), .O_PLUS_X_SWITCH(outs[2]),
    .O_MINUS_Y_SWITCH(outs[1]), .O_MINUS_X_SWITCH(outs[0]),
    .O_EXTERNAL_IRQ_LINE_TWO(ext), .O_IRQ(irq));
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Sample at the edge where pready is seen; no fixed wait assumed
    do @(posedge clk); while (pready !== 1'b1 && cycles < 20000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    wait_cyc(5);
    rst_b <= 1'b1;
    `CHK("outs_rst", 5'h00, outs)
    apb(1'b0, 12'h0AC, 32'h0);
    `CHK("ctrl_rst", 32'h0, rd)
    apb(1'b0, 12'h0B0, 32'h0);
    `CHK("db_rst", 32'h0, rd)
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, {24'h0, rows[i].w});
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("readback", {24'h0, rows[i].r}, rd)
      `CHK("switches", rows[i].o, outs)
    end
    $display("test table done");
    apb(1'b0, 12'h100, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, rd)
    // Unaligned write must be refused and leave the control alone
    apb(1'b1, 12'h0AD, 32'hFF);
    `CHK("unaligned_err", 1'b1, err)
    apb(1'b0, 12'h0AC, 32'h0);
    `CHK("unaligned_wr", 32'h0A, rd)
    // Interface off: raw contact must stay invisible
    apb(1'b1, 12'h0B0, 32'h0);
    apb(1'b1, 12'h0AC, 32'h10);
    press <= 1'b1;
    wait_cyc(6);
    apb(1'b0, 12'h0AC, 32'h0);
    `CHK("off_flag", 32'h10, rd)
    `CHK("off_ext", 1'b0, ext)
    $display("test disabled done");
    apb(1'b1, 12'h0AC, 32'h90);
    wait_cyc(3);
    `CHK("ext_on", 1'b1, ext)
    `CHK("irq_on", 1'b1, irq)
    apb(1'b0, 12'h0AC, 32'h0);
    `CHK("flag_on", 32'hB0, rd)
    apb(1'b1, 12'h0AC, 32'h80);
    wait_cyc(2);
    `CHK("ext_gated", 1'b0, ext)
    apb(1'b0, 12'h0B4, 32'h0);
    `CHK("status", 32'h1, rd & 32'h1)
    wait_cyc(2);
    `CHK("irq_clear", 1'b0, irq)
    press <= 1'b0;
    wait_cyc(3);
    apb(1'b0, 12'h0AC, 32'h0);
    `CHK("flag_off", 32'h80, rd)
    $display("test direct touch done");
    apb(1'b1, 12'h0AC, 32'h90);
    for (int k = 1; k <= 2; k++) begin
      iv = k * 64 - 16;
      apb(1'b1, 12'h0B0, {24'h0, 8'h80 | k[7:0]});
      // Short bounce below the interval must be filtered out
      press <= 1'b1;
      wait_cyc(iv - 10);
      press <= 1'b0;
      wait_cyc(iv);
      `CHK("bounce_ext", 1'b0, ext)
      press <= 1'b1;
      wait_cyc(iv - 6);
      `CHK("early_ext", 1'b0, ext)
      wait_cyc(12);
      `CHK("late_ext", 1'b1, ext)
      press <= 1'b0;
      wait_cyc(4);
      `CHK("rel_ext", 1'b0, ext)
    end
    apb(1'b1, 12'h0B8, 32'h0);
    apb(1'b0, 12'h0B4, 32'h0);
    press <= 1'b1;
    // Long enough for the 112 cycle interval to pass, so an event occurs
    wait_cyc(120);
    `CHK("masked_ext", 1'b1, ext)
    `CHK("masked_irq", 1'b0, irq)
    apb(1'b0, 12'h0B4, 32'h0);
    `CHK("masked_status", 32'h1, rd)
    $display("test debounce done");
    // Reset in mid-run with a touch held and the panel configured
    rst_b <= 1'b0;
    wait_cyc(2);
    `CHK("mid_outs", 5'h00, outs)
    `CHK("mid_ext", 1'b0, ext)
    `CHK("mid_irq", 1'b0, irq)
    rst_b <= 1'b1;
    apb(1'b0, 12'h0AC, 32'h0);
    `CHK("mid_ctrl", 32'h0, rd)
    apb(1'b0, 12'h0B0, 32'h0);
    `CHK("mid_db", 32'h0, rd)
    $display("test mid reset done");
    give_verdict();
  end
endmodule
